// *** ims_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// far slave: acks its address and writes, answers each read byte with TXB until the master withholds ack
module ims_bus_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [7:0] TXB  = 8'ha5
) (
  input  wire logic scl,
  input  wire logic sda,
  output var  logic sda_oe
);
  logic [7:0] sh;
  int         n = 0;
  logic       ap = 1'b0, sel = 1'b0, rd = 1'b0, rdg = 1'b0;
  initial sda_oe = 1'b0;
  always @(negedge sda) if (scl) begin
    n = 0;
    ap = 1'b1;
    sel = 1'b0;
    rdg = 1'b0;
  end
  always @(posedge sda) if (scl) begin
    sel = 1'b0;
    rdg = 1'b0;
  end
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    n = n + 1;
  end
  // released line floats to the pull-up, never holds old data
  always @(negedge scl) begin
    sda_oe = 1'b0;
    if (n == 8 && ap) begin
      sel = (sh[7:1] == ADDR);
      rd = sh[0];
      ap = 1'b0;
    end
    if (n == 8) sda_oe = sel && !rdg;
    if (n == 9) begin
      n = 0;
      rdg = sel && rd && !sh[0];
    end
    if (rdg && n < 8) sda_oe = !TXB[7-n];
  end
endmodule // ims_bus_model
`default_nettype wire

// *** ims_defs.vh ***
`ifndef IMS_DEFS_VH
`define IMS_DEFS_VH
`define IMS_DIV_W        8
`define IMS_DIV_HI_MSB   15
`define IMS_DIV_HI_LSB   8
`define IMS_DIV_LO_MSB   7
`define IMS_DIV_LO_LSB   0
`define IMS_DIV_EXTRA    8'h02
`define IMS_DIV_RESET    16'h3232
`define IMS_ADDR_RESET   8'h00
`define IMS_ST_IDLE      3'h0
`define IMS_ST_START     3'h1
`define IMS_ST_BIT       3'h2
`define IMS_ST_ACK       3'h3
`define IMS_ST_STOP      3'h4
`define IMS_ST_LOST      3'h5
`define IMS_BITS_MAX     4'h8
`endif

// *** ims_i2c_port.v ***
`timescale 1ns/1ps
`default_nettype none
// Function
// (RULE1) data and clock pins are open-drain, only ever pulled low
// (RULE2) two identical instances; master and slave raise separate interrupts
// (RULE3) slave answers to four programmed addresses, one per register
// (RULE4) software changes slave addresses only while bus is not busy
// (RULE5) master starts only on idle bus: start, address, direction bit
// (RULE6) data follows address only with arbitration kept and ack; stop ends
// (RULE7) master and slave run independently, may be active together
// (RULE8) slave wakes on every start; on mismatch idles until next start
// (RULE9) master losing arbitration can still be addressed as slave
// (RULE10) master makes serial clock, 100 kHz and 400 kHz supported
// (RULE11) rate = clk / ((2+high count)+(2+low count)); high count upper byte; code holds each bit's high phase 2 cycles more, until scl syncs high
// (RULE12) software loads CF for 100 kHz, 32 for 400 kHz, both counts
// (RULE13) first address byte compared, upper seven bits, against all four
// (RULE14) lowest bit of each address register ignored in comparison
// (RULE15) slave reports two-bit index of matched address register
// (RULE16) master with full receive buffer withholds ack, flags no-ack
// (RULE17) matched slave drives ack low on ninth clock of address byte
// (RULE18) on arbitration loss master releases both lines at once
`include "ims_defs.vh"
module ims_i2c_port (
  input  wire        clk,
  input  wire        nrst,
  input  wire [15:0] serial_rate_divider_reg,
  input  wire [31:0] slave_match_address_regs,
  input  wire        mst_go,
  input  wire [6:0]  mst_addr,
  input  wire        mst_read,
  input  wire        mst_tx_valid,
  input  wire [7:0]  mst_tx_data,
  output wire        mst_tx_ready,
  input  wire        mst_rx_full,
  input  wire        mst_last,
  output reg  [7:0]  mst_rx_data,
  output reg         mst_rx_valid,
  output reg         mst_busy,
  output reg         mst_lost,
  output reg         mst_nack,
  output reg         mst_irq,
  output reg         slv_active,
  output reg  [1:0]  slv_id,
  output reg  [7:0]  slv_rx_data,
  output reg         slv_rx_valid,
  output reg         slv_irq,
  output wire        bus_busy,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe,
  input  wire        scl_i,
  output wire        scl_o,
  output wire        scl_oe
);
  wire sda_s;
  wire scl_s;
  ims_sync u_sda (.clk(clk), .nrst(nrst), .d(sda_i), .q(sda_s));
  ims_sync u_scl (.clk(clk), .nrst(nrst), .d(scl_i), .q(scl_s));
  reg sda_p_q;
  reg scl_p_q;
  reg busy_q;
  wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  assign bus_busy = busy_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_p_q <= 1'b1;
      scl_p_q <= 1'b1;
      busy_q  <= 1'b0;
    end else begin
      sda_p_q <= sda_s;
      scl_p_q <= scl_s;
      if (start_ev)
        busy_q <= 1'b1;
      else if (stop_ev)
        busy_q <= 1'b0;
    end
  end
  // master: independent of slave below (RULE7)
  wire [7:0] hi_cnt = serial_rate_divider_reg[`IMS_DIV_HI_MSB:`IMS_DIV_HI_LSB];
  wire [7:0] lo_cnt = serial_rate_divider_reg[`IMS_DIV_LO_MSB:`IMS_DIV_LO_LSB];
  reg  [2:0] m_st_q;
  reg  [8:0] m_cnt_q;
  reg        m_scl_q;
  reg        m_sda_q;
  reg  [3:0] m_bit_q;
  reg  [7:0] m_sh_q;
  reg        m_addr_ph_q;
  reg        m_rd_q;
  wire [8:0] hi_len = {1'b0, hi_cnt} + {1'b0, `IMS_DIV_EXTRA}; // RULE11
  wire [8:0] lo_len = {1'b0, lo_cnt} + {1'b0, `IMS_DIV_EXTRA}; // RULE11
  wire       m_drv = (m_st_q != `IMS_ST_IDLE) && (m_st_q != `IMS_ST_LOST);
  wire       m_ph_end = (m_cnt_q == 9'h001);
  // data moves two cycles into the low phase, never on an scl edge
  wire       m_lo_first = ~m_scl_q & (m_cnt_q == lo_len - 9'h001);
  // stretched clock holds the count while another device keeps scl low
  wire       m_hold = m_scl_q & ~scl_s;
  // lost when we release sda but line reads low at scl high
  wire       m_lose = m_drv & m_sda_q & ~sda_s & scl_s & m_scl_q &
                      (m_st_q == `IMS_ST_BIT) & ~(m_rd_q & ~m_addr_ph_q);
  assign mst_tx_ready = (m_st_q == `IMS_ST_ACK) & m_ph_end & m_scl_q &
                        ~m_rd_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      m_st_q <= `IMS_ST_IDLE;
      m_cnt_q <= 9'h000;
      m_scl_q <= 1'b1;
      m_sda_q <= 1'b1;
      m_bit_q <= 4'h0;
      m_sh_q <= 8'h00;
      m_addr_ph_q <= 1'b0;
      m_rd_q <= 1'b0;
      mst_rx_data <= 8'h00;
      mst_rx_valid <= 1'b0;
      mst_busy <= 1'b0;
      mst_lost <= 1'b0;
      mst_nack <= 1'b0;
      mst_irq <= 1'b0;
    end else begin
      mst_rx_valid <= 1'b0;
      mst_irq <= 1'b0;
      if (!m_hold && m_cnt_q != 9'h000)
        m_cnt_q <= m_cnt_q - 9'h001;
      if (m_lose) begin
        m_st_q <= `IMS_ST_LOST; // RULE18
        m_scl_q <= 1'b1;
        m_sda_q <= 1'b1;
        mst_lost <= 1'b1;
        mst_irq <= 1'b1; // RULE2
      end else begin
        case (m_st_q)
          `IMS_ST_IDLE: begin
            mst_busy <= 1'b0;
            if (mst_go && !busy_q) begin // RULE5
              m_st_q <= `IMS_ST_START;
              m_sda_q <= 1'b0;
              m_cnt_q <= hi_len;
              m_sh_q <= {mst_addr, mst_read}; // RULE5
              m_rd_q <= mst_read;
              m_addr_ph_q <= 1'b1;
              mst_busy <= 1'b1;
              mst_nack <= 1'b0;
              mst_lost <= 1'b0;
            end
          end
          `IMS_ST_START: if (m_ph_end) begin
            m_scl_q <= 1'b0;
            m_cnt_q <= lo_len;
            m_bit_q <= 4'h0;
            m_st_q <= `IMS_ST_BIT;
          end
          `IMS_ST_BIT: if (m_ph_end) begin
            if (!m_scl_q) begin
              m_scl_q <= 1'b1;
              m_cnt_q <= hi_len; // RULE10
            end else begin
              m_sh_q <= {m_sh_q[6:0], sda_s};
              m_scl_q <= 1'b0;
              m_cnt_q <= lo_len;
              m_bit_q <= m_bit_q + 4'h1;
              if (m_bit_q == `IMS_BITS_MAX - 4'h1)
                m_st_q <= `IMS_ST_ACK;
            end
          end else if (m_lo_first) begin
            m_sda_q <= (m_rd_q & ~m_addr_ph_q) ? 1'b1 : m_sh_q[7];
          end
          `IMS_ST_ACK: if (m_ph_end) begin
            if (!m_scl_q) begin
              if (m_rd_q & ~m_addr_ph_q & mst_rx_full)
                mst_nack <= 1'b1; // RULE16
              if (m_rd_q & ~m_addr_ph_q & ~mst_rx_full) begin
                mst_rx_data <= m_sh_q;
                mst_rx_valid <= 1'b1;
              end
              m_scl_q <= 1'b1;
              m_cnt_q <= hi_len;
            end else begin
              m_scl_q <= 1'b0;
              m_cnt_q <= lo_len;
              m_bit_q <= 4'h0;
              m_addr_ph_q <= 1'b0;
              mst_irq <= 1'b1; // RULE2
              if ((~m_rd_q | m_addr_ph_q) & sda_s) begin
                mst_nack <= 1'b1;
                m_st_q <= `IMS_ST_STOP; // RULE6
              end else if (m_rd_q & ~m_addr_ph_q &
                           (mst_last | mst_rx_full)) begin
                m_st_q <= `IMS_ST_STOP;
              end else if (m_rd_q) begin
                m_st_q <= `IMS_ST_BIT; // RULE6
              end else if (mst_tx_valid) begin
                m_sh_q <= mst_tx_data;
                m_st_q <= `IMS_ST_BIT;
              end else begin
                m_st_q <= `IMS_ST_STOP; // RULE6
              end
            end
          end else if (m_lo_first) begin
            // receiving: ack unless buffer full or last byte (RULE16)
            m_sda_q <= (m_rd_q & ~m_addr_ph_q) ?
                       (mst_rx_full | mst_last) : 1'b1;
          end
          `IMS_ST_STOP: if (m_ph_end) begin
            if (!m_scl_q) begin
              m_scl_q <= 1'b1;
              m_cnt_q <= hi_len;
            end else begin
              m_sda_q <= 1'b1; // RULE6
              m_st_q <= `IMS_ST_IDLE;
            end
          end else if (m_lo_first) begin
            // one low phase only: sda drops while scl is low
            m_sda_q <= 1'b0;
          end
          `IMS_ST_LOST: if (!busy_q) begin
            m_st_q <= `IMS_ST_IDLE;
            mst_lost <= 1'b0;
          end
          default: m_st_q <= `IMS_ST_IDLE;
        endcase
      end
    end
  end
  // slave: sees every start, even one this master made (RULE9)
  reg  [3:0] s_bit_q;
  reg  [7:0] s_sh_q;
  reg        s_first_q;
  reg        s_ack_q;
  reg        s_drv_q;
  reg        s_awake_q;
  wire [3:0] hit;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_cmp
      assign hit[g] = (slave_match_address_regs[8*g+7:8*g+1] ==
                       s_sh_q[7:1]); // RULE13 RULE14
    end
  endgenerate
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_bit_q <= 4'h0;
      s_sh_q <= `IMS_ADDR_RESET;
      s_first_q <= 1'b0;
      s_ack_q <= 1'b0;
      s_drv_q <= 1'b0;
      s_awake_q <= 1'b0;
      slv_active <= 1'b0;
      slv_id <= 2'b00;
      slv_rx_data <= 8'h00;
      slv_rx_valid <= 1'b0;
      slv_irq <= 1'b0;
    end else begin
      slv_rx_valid <= 1'b0;
      slv_irq <= 1'b0;
      if (start_ev) begin
        s_awake_q <= 1'b1; // RULE8
        s_first_q <= 1'b1;
        s_bit_q <= 4'h0;
        s_drv_q <= 1'b0;
        slv_active <= 1'b0;
      end else if (stop_ev) begin
        s_awake_q <= 1'b0;
        s_drv_q <= 1'b0;
        if (slv_active)
          slv_irq <= 1'b1;
        slv_active <= 1'b0;
      end else if (s_awake_q) begin
        if (scl_rise && s_bit_q != `IMS_BITS_MAX) begin
          s_sh_q <= {s_sh_q[6:0], sda_s};
          s_bit_q <= s_bit_q + 4'h1;
        end else if (scl_fall && s_bit_q == `IMS_BITS_MAX) begin
          if (s_ack_q) begin
            s_drv_q <= 1'b0;
            s_ack_q <= 1'b0;
            s_bit_q <= 4'h0;
          end else if (s_first_q) begin
            s_first_q <= 1'b0;
            if (|hit) begin
              s_drv_q <= 1'b1; // RULE17
              s_ack_q <= 1'b1;
              slv_active <= 1'b1;
              slv_irq <= 1'b1; // RULE2
              slv_id <= hit[0] ? 2'b00 : hit[1] ? 2'b01 :
                        hit[2] ? 2'b10 : 2'b11; // RULE15 RULE3
            end else begin
              s_awake_q <= 1'b0; // RULE8
            end
          end else if (slv_active) begin
            slv_rx_data <= s_sh_q;
            slv_rx_valid <= 1'b1;
            s_drv_q <= 1'b1;
            s_ack_q <= 1'b1;
          end
        end
      end
    end
  end
  // wired-AND: only ever pull low, release otherwise (RULE1)
  assign sda_o  = 1'b0;
  assign scl_o  = 1'b0;
  assign sda_oe = (m_drv & ~m_sda_q) | s_drv_q; // RULE1
  assign scl_oe = m_drv & ~m_scl_q; // RULE1
endmodule // ims_i2c_port
`default_nettype wire

// *** ims_i2c_port_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module ims_i2c_port_asserts (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [15:0] serial_rate_divider_reg,
  input wire logic        mst_go,
  input wire logic        mst_busy,
  input wire logic        mst_lost,
  input wire logic        slv_active,
  input wire logic        bus_busy,
  input wire logic        sda_i,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        scl_o,
  input wire logic        scl_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // cycles the master has held the clock line low
  logic [8:0] low_q;
  always @(posedge clk or negedge nrst)
    if (!nrst) low_q <= 9'h000;
    else low_q <= scl_oe ? low_q + 9'h001 : 9'h000;
  sequence s_go;
    mst_go && !mst_busy && !bus_busy;
  endsequence
  sequence s_start;
    $fell(sda_i) && scl_i && $past(scl_i);
  endsequence
  a_open_drain: assert property (!sda_o && !scl_o)
    else $error("pin driven high");
  a_go_start: assert property (s_go |=> sda_oe && mst_busy)
    else $error("no start after go");
  a_idle_scl: assert property (!mst_busy && !$past(mst_busy) |-> !scl_oe)
    else $error("clock driven while idle");
  a_scl_low: assert property ($fell(scl_oe) && mst_busy && !mst_lost
    |-> low_q == {1'b0, serial_rate_divider_reg[7:0]} + 9'h002)
    else $error("low phase length wrong");
  a_lost_free: assert property ($rose(mst_lost)
    |-> ##1 !scl_oe && (slv_active || !sda_oe))
    else $error("lines held after loss");
  a_bus_start: assert property (s_start |-> ##[1:5] bus_busy)
    else $error("start not seen");
  a_bus_stop: assert property ($rose(sda_i) && scl_i && $past(scl_i)
    |-> ##[1:5] !bus_busy)
    else $error("stop not seen");
  a_slv_wake: assert property ($rose(slv_active) |-> bus_busy)
    else $error("slave active outside transfer");
endmodule // ims_i2c_port_asserts
`default_nettype wire

// *** ims_sync.v ***
`timescale 1ns/1ps
`default_nettype none
// two flip-flop synchroniser for one pin level
module ims_sync (
  input  wire clk,
  input  wire nrst,
  input  wire d,
  output wire q
);
  reg s1_q;
  reg s2_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // ims_sync
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] div = 16'h0202;
  logic [31:0] ids = 32'h0000_0000;
  logic [6:0]  addr = 7'h00;
  logic [7:0]  td = 8'h00, mrx, srx_q;
  logic [1:0]  sid_q;
  logic        go = 1'b0, rd = 1'b0, tv = 1'b0, full = 1'b0;
  logic        tb_sda = 1'b0, act_q, m_oe;
  wire logic   tx_rdy, rxv, busy, lost, nack, sact, srxv, bbusy;
  wire logic   sda_oe, scl_oe;
  wire logic [7:0] rxd, srx;
  wire logic [1:0] sid;
  wire logic   scl = !scl_oe;
  wire logic   sda = !(sda_oe | m_oe | tb_sda);
  int          checked = 0, n_mismatch = 0;
  always #5 clk = !clk;
  ims_i2c_port DUT (.clk, .nrst, .serial_rate_divider_reg(div),
    .slave_match_address_regs(ids), .mst_go(go), .mst_addr(addr),
    .mst_read(rd), .mst_tx_valid(tv), .mst_tx_data(td),
    .mst_tx_ready(tx_rdy), .mst_rx_full(full), .mst_last(rd),
    .mst_rx_data(rxd), .mst_rx_valid(rxv), .mst_busy(busy),
    .mst_lost(lost), .mst_nack(nack), .mst_irq(), .slv_active(sact),
    .slv_id(sid), .slv_rx_data(srx), .slv_rx_valid(srxv), .slv_irq(),
    .bus_busy(bbusy), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe));
  ims_bus_model u_far (.scl(scl), .sda(sda), .sda_oe(m_oe));
  always @(posedge clk) begin
    if (rxv) mrx <= rxd;
    if (srxv) srx_q <= srx;
    if (sact) sid_q <= sid;
    if (sact) act_q <= 1'b1;
  end
  task automatic chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one whole transfer; byte handed over only once it is taken
  task automatic xfer(input logic [6:0] a, input logic r, f);
    int k;
    logic t;
    @(negedge clk);
    act_q = 1'b0;
    addr = a;
    rd = r;
    full = f;
    tv = !r;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (k = 0; k < 5000 && (busy || bbusy); k++) begin
      t = tx_rdy;
      @(negedge clk);
      if (t) tv = 1'b0;
    end
  endtask
  task automatic t_self;
    int i;
    ids = 32'h7e63_4021;
    for (i = 0; i < 4; i++) begin
      td = 8'h3c + 8'(i);
      xfer(ids[8*i+1 +: 7], 1'b0, 1'b0);
      chk(8'(sid_q), 8'(i));
      chk(srx_q, td);
      chk(8'(act_q), 8'h01);
      chk(8'(nack), 8'h00);
    end
    $display("t_self done");
  endtask
  task automatic t_far;
    td = 8'h96;
    xfer(7'h2a, 1'b0, 1'b0);
    chk(8'(act_q), 8'h00);
    chk(8'(nack), 8'h00);
    xfer(7'h2a, 1'b1, 1'b0);
    chk(mrx, 8'ha5);
    xfer(7'h2a, 1'b1, 1'b1);
    chk(8'(nack), 8'h01);
    xfer(7'h11, 1'b0, 1'b0);
    chk(8'(nack), 8'h01);
    chk(8'(bbusy), 8'h00);
    $display("t_far done");
  endtask
  // a rival pulls data low so the first address bit, bit 6, is lost
  task automatic t_lost;
    int k;
    @(negedge clk);
    addr = 7'h7f;
    rd = 1'b0;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (k = 0; k < 500 && !scl_oe; k++) @(negedge clk);
    tb_sda = 1'b1;
    for (k = 0; k < 500 && !lost; k++) @(negedge clk);
    chk(8'(lost), 8'h01);
    repeat (4) @(negedge clk);
    chk(8'(scl_oe), 8'h00);
    tb_sda = 1'b0;
    repeat (10) @(negedge clk);
    chk(8'(bbusy), 8'h00);
    $display("t_lost done");
  endtask
  task automatic t_fast;
    div = 16'h3232;
    td = 8'h5a;
    xfer(7'h10, 1'b0, 1'b0);
    chk(srx_q, 8'h5a);
    div = 16'h0202;
    $display("t_fast done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    t_self;
    t_far;
    t_lost;
    t_fast;
    results;
  end
  initial begin
    #500us;
    n_mismatch++;
    results;
  end
endmodule // tb_top
bind ims_i2c_port ims_i2c_port_asserts u_chk (.clk, .nrst,
  .serial_rate_divider_reg, .mst_go, .mst_busy, .mst_lost, .slv_active,
  .bus_busy, .sda_i, .scl_i, .sda_o, .sda_oe, .scl_o, .scl_oe);
`default_nettype wire
